// File: hdl/sxs_exec.sv
// Execution unit for subtract, swap, exclusive-OR, direction load and power-down
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sxs_exec
	import sxs_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	output logic [DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Wake-up request pin
	input wire logic WAKE_PIN,
	// Port direction registers
	output logic [BYTE_W-1:0] PORT_A_DIRECTION,
	output logic [BYTE_W-1:0] PORT_B_DIRECTION,
	output logic [BYTE_W-1:0] PORT_C_DIRECTION,
	// Power state
	output logic SLEEPING
);

	sxs_state_s st_ff;
	sxs_state_s nxt_st;
	sxs_alu_in_s alu_in;
	sxs_alu_out_s alu_out;

	function automatic logic file_hit(input logic [ADDR_W-1:0] addr);
		file_hit = (addr[ADDR_W-1:FILE_PAGE_LSB] == FILE_PAGE);
	endfunction : file_hit

	function automatic logic [FILE_W-1:0] file_idx(input logic [ADDR_W-1:0] addr);
		file_idx = addr[FILE_IDX_MSB:FILE_IDX_LSB];
	endfunction : file_idx

	function automatic logic op_legal(input logic [DATA_W-1:0] word);
		logic [OP_W-1:0] op;
		logic [FILE_W-1:0] sel;
		op = word[OP_LSB +: OP_W];
		sel = word[F_LSB +: FILE_W];
		op_legal = (op <= OP_POWER_DOWN);
		if (op == OP_LOAD_DIR) begin
			op_legal = (sel >= DIR_SEL_A) && (sel <= DIR_SEL_C);
		end
	endfunction : op_legal

	// Refusals show as PSLVERR; a refused write changes nothing
	function automatic logic access_error(
		input logic [ADDR_W-1:0] addr,
		input logic wr,
		input logic [DATA_W-1:0] word,
		input logic asleep
	);
		access_error = 1'b1;
		if (file_hit(addr)) begin
			access_error = 1'b0;
		end else begin
			case (addr)
				OFS_EXEC: begin
					access_error = wr && (asleep || !op_legal(word));
				end
				OFS_ACC, OFS_STATUS: begin
					access_error = 1'b0;
				end
				OFS_DIR, OFS_WATCH: begin
					access_error = wr;
				end
				default: begin
					access_error = 1'b1;
				end
			endcase
		end
	endfunction : access_error

	// Opcode, file select and literal come straight from the held write data of the execute access; W and carry come from state
	always_comb begin
		alu_in.op = sxs_op_e'(PWDATA[OP_LSB +: OP_W]);
		alu_in.w = st_ff.acc;
		alu_in.f = st_ff.regs[PWDATA[F_LSB +: FILE_W]];
		alu_in.k = PWDATA[K_LSB +: BYTE_W];
		alu_in.c_in = st_ff.carry;
	end

	sxs_alu u_alu (
		.alu_in(alu_in),
		.alu_out(alu_out)
	);

	always_comb begin
		logic req;
		logic commit;
		logic [DATA_W-1:0] rd;
		logic [FILE_W-1:0] fsel;
		logic dest_file;
		logic wake_now;
		req = 1'b0;
		commit = 1'b0;
		rd = '0;
		fsel = '0;
		dest_file = 1'b0;
		wake_now = 1'b0;
		nxt_st = st_ff;

		// Pin is asynchronous; only the second stage is looked at
		nxt_st.wake_sync = {st_ff.wake_sync[0], WAKE_PIN};

		// One wait state: request taken in the first access cycle,
		// answered in the second, committed on the edge that samples PREADY
		req = PSEL && PENABLE && !st_ff.pready;
		commit = PSEL && PENABLE && st_ff.pready && PWRITE && !st_ff.pslverr;
		nxt_st.pready = 1'b0;
		nxt_st.pslverr = 1'b0;

		if (req) begin
			nxt_st.pready = 1'b1;
			nxt_st.pslverr = access_error(PADDR, PWRITE, PWDATA, st_ff.fsm == FSM_SLEEP);
			if (!PWRITE) begin
				if (file_hit(PADDR)) begin
					rd[BYTE_W-1:0] = st_ff.regs[file_idx(PADDR)];
				end else begin
					case (PADDR)
						OFS_EXEC: begin
							rd[INSTR_W-1:0] = st_ff.last_instr;
						end
						OFS_ACC: begin
							rd[BYTE_W-1:0] = st_ff.acc;
						end
						OFS_STATUS: begin
							rd[STS_C] = st_ff.carry;
							rd[STS_HC] = st_ff.half_carry_flag;
							rd[STS_Z] = st_ff.zero;
							rd[STS_PWR] = st_ff.power_down_flag;
							rd[STS_TMO] = st_ff.time_out_flag;
							rd[STS_SLEEP] = (st_ff.fsm == FSM_SLEEP);
						end
						OFS_DIR: begin
							rd[BYTE_W-1:0] = st_ff.port_a_direction;
							rd[DIR_B_LSB +: BYTE_W] = st_ff.port_b_direction;
							rd[DIR_C_LSB +: BYTE_W] = st_ff.port_c_direction;
						end
						OFS_WATCH: begin
							rd[BYTE_W-1:0] = st_ff.watchdog_counter;
							rd[WATCH_PRE_LSB +: BYTE_W] = st_ff.prescaler;
						end
						default: begin
							rd = '0;
						end
					endcase
				end
				nxt_st.prdata = rd;
			end
		end

		unique case (st_ff.fsm)
			FSM_RUN: begin
				// Watchdog runs off the core clock; it is frozen while asleep
				{nxt_st.watchdog_counter, nxt_st.prescaler} =
					{st_ff.watchdog_counter, st_ff.prescaler} + 16'h0001;
			end
			FSM_SLEEP: begin
				wake_now = st_ff.wake_sync[1];
				if (commit && PADDR == OFS_STATUS && PWDATA[STS_WAKE]) begin
					wake_now = 1'b1;
				end
				if (wake_now) begin
					nxt_st.fsm = FSM_RUN;
				end
			end
		endcase

		if (commit) begin
			fsel = PWDATA[F_LSB +: FILE_W];
			dest_file = (PWDATA[DEST_BIT] != DEST_ACC);
			if (file_hit(PADDR)) begin
				nxt_st.regs[file_idx(PADDR)] = PWDATA[BYTE_W-1:0];
			end else begin
				case (PADDR)
					OFS_ACC: begin
						nxt_st.acc = PWDATA[BYTE_W-1:0];
					end
					OFS_STATUS: begin
						nxt_st.carry = PWDATA[STS_C];
						nxt_st.half_carry_flag = PWDATA[STS_HC];
						nxt_st.zero = PWDATA[STS_Z];
					end
					OFS_EXEC: begin
						nxt_st.last_instr = PWDATA[INSTR_W-1:0];
						if (alu_out.upd_c) begin
							nxt_st.carry = alu_out.c;
							nxt_st.half_carry_flag = alu_out.hc;
						end
						if (alu_out.upd_z) begin
							nxt_st.zero = alu_out.z;
						end
						unique case (alu_in.op)
							OP_SUB_LIT, OP_XOR_LIT: begin
								nxt_st.acc = alu_out.result;
							end
							OP_SUB_FILE, OP_SUB_BORROW, OP_SWAP, OP_XOR_FILE: begin
								if (dest_file) begin
									nxt_st.regs[fsel] = alu_out.result;
								end else begin
									nxt_st.acc = alu_out.result;
								end
							end
							OP_LOAD_DIR: begin
								case (fsel)
									DIR_SEL_A: nxt_st.port_a_direction = st_ff.acc;
									DIR_SEL_B: nxt_st.port_b_direction = st_ff.acc;
									DIR_SEL_C: nxt_st.port_c_direction = st_ff.acc;
									default: nxt_st.port_a_direction = st_ff.port_a_direction;
								endcase
							end
							OP_POWER_DOWN: begin
								nxt_st.power_down_flag = 1'b0;
								nxt_st.time_out_flag = 1'b1;
								nxt_st.watchdog_counter = '0;
								nxt_st.prescaler = '0;
								nxt_st.fsm = FSM_SLEEP;
							end
						endcase
					end
					default: begin
						nxt_st.acc = st_ff.acc;
					end
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_ff <= SXS_STATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign PRDATA = st_ff.prdata;
	assign PREADY = st_ff.pready;
	assign PSLVERR = st_ff.pslverr;
	assign PORT_A_DIRECTION = st_ff.port_a_direction;
	assign PORT_B_DIRECTION = st_ff.port_b_direction;
	assign PORT_C_DIRECTION = st_ff.port_c_direction;
	assign SLEEPING = (st_ff.fsm == FSM_SLEEP);

endmodule : sxs_exec
`default_nettype wire

// File: hdl/sxs_pkg.sv
// Shared constants, types and state layout for the execution unit
package sxs_pkg;

	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register map, byte addresses
	localparam logic [ADDR_W-1:0] OFS_EXEC = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_ACC = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_DIR = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_WATCH = 12'h010;

	// File registers occupy 0x200..0x3FC, one word per register
	localparam logic [2:0] FILE_PAGE = 3'h1;
	localparam int FILE_PAGE_LSB = 9;
	localparam int FILE_IDX_LSB = 2;
	localparam int FILE_IDX_MSB = 8;
	localparam int FILE_DEPTH = 128;
	localparam int FILE_W = 7;

	// Instruction word written to the execute register
	localparam int K_LSB = 0;
	localparam int F_LSB = 8;
	localparam int DEST_BIT = 15;
	localparam int OP_LSB = 16;
	localparam int OP_W = 4;
	localparam int INSTR_W = 20;
	localparam logic DEST_ACC = 1'b0;

	// Status register bits
	localparam int STS_C = 0;
	localparam int STS_HC = 1;
	localparam int STS_Z = 2;
	localparam int STS_PWR = 3;
	localparam int STS_TMO = 4;
	localparam int STS_SLEEP = 5;
	localparam int STS_WAKE = 6;

	// Watch register layout
	localparam int WATCH_PRE_LSB = 8;

	// Direction register selectors and reset value
	localparam logic [FILE_W-1:0] DIR_SEL_A = 7'h05;
	localparam logic [FILE_W-1:0] DIR_SEL_B = 7'h06;
	localparam logic [FILE_W-1:0] DIR_SEL_C = 7'h07;
	localparam logic [BYTE_W-1:0] DIR_RST = 8'hFF;
	localparam int DIR_B_LSB = 8;
	localparam int DIR_C_LSB = 16;

	typedef enum logic [OP_W-1:0] {
		OP_SUB_LIT = 4'h0,
		OP_SUB_FILE = 4'h1,
		OP_SUB_BORROW = 4'h2,
		OP_SWAP = 4'h3,
		OP_XOR_LIT = 4'h4,
		OP_XOR_FILE = 4'h5,
		OP_LOAD_DIR = 4'h6,
		OP_POWER_DOWN = 4'h7
	} sxs_op_e;

	typedef enum logic [1:0] {
		FSM_RUN = 2'b01,
		FSM_SLEEP = 2'b10
	} sxs_fsm_e;

	typedef struct packed {
		sxs_op_e op;
		logic [BYTE_W-1:0] w;
		logic [BYTE_W-1:0] f;
		logic [BYTE_W-1:0] k;
		logic c_in;
	} sxs_alu_in_s;

	typedef struct packed {
		logic [BYTE_W-1:0] result;
		logic c;
		logic hc;
		logic z;
		logic upd_c;
		logic upd_z;
	} sxs_alu_out_s;

	typedef struct packed {
		sxs_fsm_e fsm;
		logic [BYTE_W-1:0] acc;
		logic carry;
		logic half_carry_flag;
		logic zero;
		logic power_down_flag;
		logic time_out_flag;
		logic [BYTE_W-1:0] port_a_direction;
		logic [BYTE_W-1:0] port_b_direction;
		logic [BYTE_W-1:0] port_c_direction;
		logic [BYTE_W-1:0] watchdog_counter;
		logic [BYTE_W-1:0] prescaler;
		logic [INSTR_W-1:0] last_instr;
		logic [FILE_DEPTH-1:0][BYTE_W-1:0] regs;
		logic [1:0] wake_sync;
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} sxs_state_s;

	localparam sxs_state_s SXS_STATE_RST = '{
		fsm: FSM_RUN,
		power_down_flag: 1'b1,
		time_out_flag: 1'b1,
		port_a_direction: DIR_RST,
		port_b_direction: DIR_RST,
		port_c_direction: DIR_RST,
		default: '0
	};

endpackage : sxs_pkg

// File: hdl/sxs_alu.sv
// Combinational datapath for subtract, swap and exclusive-OR operations
`timescale 1ns/100ps
`default_nettype none
module sxs_alu
	import sxs_pkg::*;
(
	// Operands
	input wire sxs_alu_in_s alu_in,
	// Result and flags
	output sxs_alu_out_s alu_out
);

	always_comb begin
		logic [BYTE_W:0] diff;
		logic [NIB_W:0] nib;
		logic [BYTE_W-1:0] a;
		logic cin;
		diff = '0;
		nib = '0;
		a = (alu_in.op == OP_SUB_LIT) ? alu_in.k : alu_in.f;
		// Borrow is the inverted carry, so adding carry subtracts the borrow
		cin = (alu_in.op == OP_SUB_BORROW) ? alu_in.c_in : 1'b1;
		diff = {1'b0, a} + {1'b0, ~alu_in.w} + {{BYTE_W{1'b0}}, cin};
		nib = {1'b0, a[NIB_W-1:0]} + {1'b0, ~alu_in.w[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
		alu_out = '0;
		unique case (alu_in.op)
			OP_SUB_LIT, OP_SUB_FILE, OP_SUB_BORROW: begin
				alu_out.result = diff[BYTE_W-1:0];
				alu_out.c = diff[BYTE_W];
				alu_out.hc = nib[NIB_W];
				alu_out.upd_c = 1'b1;
				alu_out.upd_z = 1'b1;
			end
			OP_SWAP: begin
				alu_out.result = {alu_in.f[NIB_W-1:0], alu_in.f[BYTE_W-1:NIB_W]};
			end
			OP_XOR_LIT: begin
				alu_out.result = alu_in.w ^ alu_in.k;
				alu_out.upd_z = 1'b1;
			end
			OP_XOR_FILE: begin
				alu_out.result = alu_in.w ^ alu_in.f;
				alu_out.upd_z = 1'b1;
			end
			default: begin
				alu_out.result = alu_in.w;
			end
		endcase
		alu_out.z = (alu_out.result == '0);
	end

endmodule : sxs_alu
`default_nettype wire

// File: bench/sxs_exec_monitor.sv
// Port-level checks for the execution unit
`timescale 1ns/100ps
`default_nettype none
module sxs_exec_monitor
	import sxs_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	input wire logic [DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Pins
	input wire logic WAKE_PIN,
	input wire logic [BYTE_W-1:0] PORT_A_DIRECTION,
	input wire logic [BYTE_W-1:0] PORT_B_DIRECTION,
	input wire logic [BYTE_W-1:0] PORT_C_DIRECTION,
	input wire logic SLEEPING
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	logic xw;
	logic ok;
	logic [3:0] op;
	logic [6:0] fi;
	assign op = PWDATA[19:16];
	assign fi = PWDATA[14:8];
	assign xw = PREADY && PWRITE && PADDR == OFS_EXEC;
	assign ok = xw && !PSLVERR && op == 4'h6;
	// Fixed single wait state keeps the master simple
	a_ready_wait: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_dir_a_load: assert property ($changed(PORT_A_DIRECTION) |-> $past(ok && fi == 7'h05))
		else $error("port A direction changed without load");
	a_dir_b_load: assert property ($changed(PORT_B_DIRECTION) |-> $past(ok && fi == 7'h06))
		else $error("port B direction changed without load");
	a_dir_c_load: assert property ($changed(PORT_C_DIRECTION) |-> $past(ok && fi == 7'h07))
		else $error("port C direction changed without load");
	a_dir_bad_sel: assert property (xw && op == 4'h6 && fi < 7'h05 |-> PSLVERR)
		else $error("bad direction selector accepted");
	a_sleep_entry: assert property (xw && !PSLVERR && op == 4'h7 |=> SLEEPING)
		else $error("power-down did not sleep");
	a_sleep_refuse: assert property (SLEEPING && xw |-> PSLVERR)
		else $error("instruction accepted while asleep");
	a_sleep_hold: assert property (SLEEPING && !WAKE_PIN && !$past(WAKE_PIN)
		&& !$past(WAKE_PIN, 2) && !(PREADY && PADDR == OFS_STATUS) |=> SLEEPING)
		else $error("left sleep without wake-up");
	a_wake_bound: assert property (SLEEPING && WAKE_PIN [*3] |-> ##[0:3] !SLEEPING)
		else $error("wake pin did not end sleep");
	c_sleep: cover property (xw && !PSLVERR && op == 4'h7);
	c_wake: cover property (SLEEPING ##1 !SLEEPING);
	c_refuse: cover property (PREADY && PSLVERR);
endmodule : sxs_exec_monitor
bind sxs_exec sxs_exec_monitor u_mon (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .WAKE_PIN(WAKE_PIN), .SLEEPING(SLEEPING),
	.PORT_A_DIRECTION(PORT_A_DIRECTION), .PORT_B_DIRECTION(PORT_B_DIRECTION),
	.PORT_C_DIRECTION(PORT_C_DIRECTION));
`default_nettype wire

// File: bench/sxs_exec_bench.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module sxs_exec_bench
	import sxs_pkg::*;
;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic WAKE_PIN = 1'b0;
	logic [ADDR_W-1:0] PADDR = '0;
	logic [DATA_W-1:0] PWDATA = '0;
	logic [DATA_W-1:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic SLEEPING;
	logic [BYTE_W-1:0] dir_a;
	logic [BYTE_W-1:0] dir_b;
	logic [BYTE_W-1:0] dir_c;
	logic [DATA_W-1:0] rd;
	logic err;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #25 SYS_CLK = ~SYS_CLK;
	sxs_exec dut (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .WAKE_PIN(WAKE_PIN), .PORT_A_DIRECTION(dir_a),
		.PORT_B_DIRECTION(dir_b), .PORT_C_DIRECTION(dir_c), .SLEEPING(SLEEPING));
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	// One APB transfer, then one idle edge so no strobe is driven twice at once
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		@(posedge SYS_CLK);
		while (PREADY !== 1'b1)
			@(posedge SYS_CLK);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask : apb
	task automatic x(input logic [3:0] op, input logic [6:0] f, input logic d, input logic [7:0] k);
		apb(1'b1, OFS_EXEC, {12'h000, op, d, f, k});
	endtask : x
	task automatic sub_case(input logic [3:0] op, input logic [7:0] w, input logic [7:0] f,
		input logic cin, input logic d);
		logic [8:0] s;
		logic [4:0] h;
		logic b;
		// Plain subtraction; a negative difference is a borrow, so carry is its inverse
		b = (op == 4'h2) && !cin;
		s = 9'(f) - 9'(w) - 9'(b);
		h = 5'(f[3:0]) - 5'(w[3:0]) - 5'(b);
		apb(1'b1, OFS_ACC, 32'(w));
		apb(1'b1, OFS_STATUS, 32'(cin));
		apb(1'b1, 12'h20C, 32'(f));
		x(op, 7'h03, d, f);
		apb(1'b0, OFS_ACC, '0);
		chk(rd, d ? 32'(w) : 32'(s[7:0]));
		apb(1'b0, 12'h20C, '0);
		chk(rd, d ? 32'(s[7:0]) : 32'(f));
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[2:0], {s[7:0] == 8'h00, !h[4], !s[8]});
	endtask : sub_case
	task automatic t_swap_xor;
		apb(1'b1, OFS_STATUS, 32'h07);
		apb(1'b1, 12'h210, 32'hC3);
		x(4'h3, 7'h04, 1'b1, 8'h00);
		apb(1'b0, 12'h210, '0);
		chk(rd, 32'h3C);
		x(4'h3, 7'h04, 1'b0, 8'h00);
		apb(1'b0, OFS_ACC, '0);
		chk(rd, 32'hC3);
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[2:0], 3'h7);
		apb(1'b1, OFS_STATUS, 32'h03);
		x(4'h4, 7'h00, 1'b0, 8'hC3);
		apb(1'b0, OFS_ACC, '0);
		chk(rd, 32'h00);
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[2:0], 3'h7);
		// Nonzero accumulator so a missing write-back shows
		apb(1'b1, OFS_ACC, 32'h0F);
		apb(1'b1, 12'h214, 32'hF0);
		x(4'h5, 7'h05, 1'b1, 8'h00);
		apb(1'b0, 12'h214, '0);
		chk(rd, 32'hFF);
		apb(1'b0, OFS_ACC, '0);
		chk(rd, 32'h0F);
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[2:0], 3'h3);
	endtask : t_swap_xor
	task automatic t_dir;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_ACC, 32'(17 * (i + 1)));
			x(4'h6, 7'(5 + i), 1'b0, 8'h00);
		end
		chk({dir_c, dir_b, dir_a}, 32'h00332211);
		apb(1'b0, OFS_DIR, '0);
		chk(rd, 32'h00332211);
		x(4'h6, 7'h04, 1'b0, 8'h00);
		chk(err, 1'b1);
		x(4'h6, 7'h08, 1'b0, 8'h00);
		chk(err, 1'b1);
		x(4'h8, 7'h05, 1'b0, 8'h00);
		chk(err, 1'b1);
		apb(1'b1, OFS_DIR, '0);
		chk(err, 1'b1);
		apb(1'b0, OFS_EXEC, '0);
		chk(rd, 32'h00060700);
		chk({dir_c, dir_b, dir_a}, 32'h00332211);
	endtask : t_dir
	// Sleep, check status and watchdog, then wake by pin or by register
	task automatic t_sleep(input logic pin);
		x(4'h7, 7'h00, 1'b0, 8'h00);
		chk(SLEEPING, 1'b1);
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[5:3], 3'b110);
		apb(1'b0, OFS_WATCH, '0);
		chk(rd[15:0], 16'h0000);
		x(4'h4, 7'h00, 1'b0, 8'hFF);
		chk(err, 1'b1);
		if (pin) begin
			WAKE_PIN <= 1'b1;
			repeat (6) @(posedge SYS_CLK);
			WAKE_PIN <= 1'b0;
		end else
			apb(1'b1, OFS_STATUS, 32'h40);
		@(posedge SYS_CLK);
		chk(SLEEPING, 1'b0);
	endtask : t_sleep
	always @(posedge SYS_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			num_errors++;
			results;
		end
	end
	initial begin
		repeat (20) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		chk({dir_c, dir_b, dir_a}, 32'h00FFFFFF);
		apb(1'b0, OFS_STATUS, '0);
		chk(rd[4:0], 5'h18);
		apb(1'b0, 12'h100, '0);
		chk(err, 1'b1);
		sub_case(4'h0, 8'h05, 8'h05, 1'b0, 1'b0);
		sub_case(4'h0, 8'h20, 8'h1F, 1'b0, 1'b0);
		sub_case(4'h1, 8'h0F, 8'h10, 1'b0, 1'b1);
		sub_case(4'h1, 8'h01, 8'h00, 1'b0, 1'b0);
		sub_case(4'h2, 8'h10, 8'h30, 1'b0, 1'b1);
		sub_case(4'h2, 8'h10, 8'h30, 1'b1, 1'b0);
		sub_case(4'h2, 8'hFF, 8'h00, 1'b1, 1'b1);
		t_swap_xor;
		t_dir;
		t_sleep(1'b1);
		t_sleep(1'b0);
		results;
	end
endmodule : sxs_exec_bench
`default_nettype wire
